// *** xmd_defines.svh ***
// Offsets, field positions, reset values and timing counts of the datapath.
// Contract
// - Every instruction reaches any data memory byte over the full address.
// - Copy accumulator to memory byte; no flag changes.
// - OR of accumulator and byte to acc or memory; only zero flag.
// - Rotate left, bit 7 into bit 0, no flags.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
// - Rotate right, bit 0 into bit 7, no flags.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Accumulator rotate forms write only the accumulator, memory untouched.
// - Subtract with borrow: acc minus byte minus inverted carry, six flags.
// - Plain subtract: acc minus byte, same six flags.
// - Subtract clears carry on negative result, sets it otherwise.
// - Decrement byte, write back, skip next when zero, no flags.
// - Accumulator decrement form writes acc only, skips on zero.
// - Increment byte, skip on zero; memory or accumulator form; no flags.
// - A taken skip inserts dummy cycles so the next instruction is dropped.
// - Taken skip lasts three cycles; failed condition just continues.
// - Set byte writes FFH to memory, flags unchanged.
// - Set bit forces the selected bit to one, others kept, no flags.
// - Byte skip-if-nonzero skips when whole byte differs from zero.
// - Bit skip-if-nonzero skips when selected bit is one.
// - Nibble swap exchanges nibbles and writes back to memory, no flags.
// - Accumulator nibble swap writes acc only, memory untouched, no flags.
`ifndef XMD_DEFINES_SVH
`define XMD_DEFINES_SVH

// ****************************************
// Register byte offsets on the APB
// ****************************************
`define XMD_OFF_CMD 8'h00
`define XMD_OFF_ACC 8'h04
`define XMD_OFF_FLAGS 8'h08
`define XMD_OFF_MADDR 8'h0C
`define XMD_OFF_MDATA 8'h10
`define XMD_OFF_INFO 8'h14

// ****************************************
// Field positions
// ****************************************
`define XMD_CMD_OP_LSB 0
`define XMD_CMD_BIT_LSB 8
`define XMD_CMD_ADDR_LSB 16
`define XMD_FLAGS_BUSY_BIT 8
`define XMD_INFO_CNT_LSB 8

// ****************************************
// Reset values and timing counts
// ****************************************
`define XMD_ACC_RST 8'h00
`define XMD_FLAGS_RST 6'h00
`define XMD_SKIP_CYCLES 2'd3
`define XMD_PLAIN_CYCLES 2'd1
`define XMD_MEM_DEPTH 1024

`endif

// *** xmd_pkg.sv ***
// Types shared by the extended memory operation datapath.
package xmd_pkg;

	// ****************************************
	// Operation codes written into the command register
	// ****************************************
	typedef enum logic [4:0] {
		XMD_COPY_ACC_TO_MEM = 5'h00,
		XMD_OR_INTO_ACC = 5'h01,
		XMD_OR_INTO_MEM = 5'h02,
		XMD_ROTATE_LEFT_MEM = 5'h03,
		XMD_ROTATE_LEFT_TO_ACC = 5'h04,
		XMD_ROTATE_LEFT_CARRY_MEM = 5'h05,
		XMD_ROTATE_LEFT_CARRY_TO_ACC = 5'h06,
		XMD_ROTATE_RIGHT_MEM = 5'h07,
		XMD_ROTATE_RIGHT_TO_ACC = 5'h08,
		XMD_ROTATE_RIGHT_CARRY_MEM = 5'h09,
		XMD_ROTATE_RIGHT_CARRY_TO_ACC = 5'h0A,
		XMD_SUB_BORROW_TO_ACC = 5'h0B,
		XMD_SUB_BORROW_TO_MEM = 5'h0C,
		XMD_MINUS_TO_ACC = 5'h0D,
		XMD_MINUS_TO_MEM = 5'h0E,
		XMD_DEC_SKIP_ZERO_MEM = 5'h0F,
		XMD_DEC_SKIP_ZERO_ACC = 5'h10,
		XMD_INC_SKIP_ZERO_MEM = 5'h11,
		XMD_INC_SKIP_ZERO_ACC = 5'h12,
		XMD_FORCE_ONES = 5'h13,
		XMD_FORCE_BIT = 5'h14,
		XMD_SKIP_IF_NONZERO = 5'h15,
		XMD_SKIP_IF_BIT_SET = 5'h16,
		XMD_NIBBLE_EXCHANGE_MEM = 5'h17,
		XMD_NIBBLE_EXCHANGE_ACC = 5'h18
	} xmd_op_t;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		XMD_IDLE = 3'b001,
		XMD_EXEC = 3'b010,
		XMD_DUMMY = 3'b100
	} xmd_state_t;

	// Status flags, packed so that bit 0 is carry.
	typedef struct packed {
		logic chained_zero_flag;
		logic signed_carry_flag;
		logic arith_wrap_flag;
		logic zero;
		logic nibble_carry_flag;
		logic carry;
	} xmd_flags_t;

	// Result of a subtract: the byte and all six flags.
	typedef struct packed {
		logic [7:0] res;
		xmd_flags_t flags;
	} xmd_sub_t;

	// Whole state of the datapath.
	typedef struct packed {
		xmd_state_t fsm;
		logic busy;
		logic [7:0] acc;
		xmd_flags_t flags;
		xmd_op_t op;
		logic [2:0] bsel;
		logic [9:0] addr;
		logic [9:0] maddr;
		logic [1:0] dcnt;
		logic [1:0] last_cyc;
		logic [7:0] skip_cnt;
		logic skip_taken;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} xmd_regs_t;

endpackage

// *** xmd_core.sv ***
// Extended data memory instruction datapath with an APB register slave.
`timescale 1ns/10ps
`include "xmd_defines.svh"

module xmd_core import xmd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy,
	output logic skip_taken
);

	// ****************************************
	// Functions
	// ****************************************

	// Subtract with an explicit borrow input; carry means no borrow.
	function automatic xmd_sub_t sub_calc(input logic [7:0] a,
		input logic [7:0] m, input logic bin, input logic cz_old,
		input logic chain);
		xmd_sub_t s;
		logic [8:0] full;
		logic [4:0] low;
		logic wrap;
		full = {1'b0, a} - {1'b0, m} - {8'h00, bin};
		low = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
		wrap = (a[7] != m[7]) && (full[7] != a[7]);
		s.res = full[7:0];
		s.flags.carry = ~full[8];
		s.flags.nibble_carry_flag = ~low[4];
		s.flags.arith_wrap_flag = wrap;
		s.flags.zero = (full[7:0] == 8'h00);
		s.flags.signed_carry_flag = full[7] ^ wrap;
		// The chained form only stays zero while every byte was zero.
		s.flags.chained_zero_flag = chain ?
			(s.flags.zero & cz_old) : s.flags.zero;
		return s;
	endfunction

	// Mask with a single bit set at the given position.
	function automatic logic [7:0] bit_mask(input logic [2:0] pos);
		return 8'h01 << pos;
	endfunction

	// Opcode legality check for the command register.
	function automatic logic op_legal(input logic [4:0] code);
		return code <= 5'h18;
	endfunction

	// ****************************************
	// State and memory
	// ****************************************
	xmd_regs_t r_reg;
	xmd_regs_t r_next;

	// Full data memory; every section is reachable by one flat address.
	logic [7:0] mem [0:`XMD_MEM_DEPTH-1];
	logic mem_we;
	logic [9:0] mem_wa;
	logic [7:0] mem_wd;
	logic [7:0] mem_byte;
	logic [7:0] mem_view;

	// Operand and buffered software view read asynchronously.
	assign mem_byte = mem[r_reg.addr];
	assign mem_view = mem[r_reg.maddr];

	// Outputs come straight from the state flops.
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign busy = r_reg.busy;
	assign skip_taken = r_reg.skip_taken;

	// ****************************************
	// Next state
	// ****************************************

	// Bus slave and instruction sequencer share one next-state process.
	always_comb begin
		logic [7:0] a;
		logic [7:0] m;
		logic [7:0] res;
		logic c;
		logic skip;
		logic acc_dst;
		logic mem_dst;
		logic access;
		logic hit;
		xmd_sub_t s;
		a = r_reg.acc;
		m = mem_byte;
		res = 8'h00;
		c = r_reg.flags.carry;
		skip = 1'b0;
		acc_dst = 1'b0;
		mem_dst = 1'b0;
		access = psel & penable & r_reg.pready;
		hit = 1'b0;
		s = '0;
		r_next = r_reg;
		r_next.skip_taken = 1'b0;
		mem_we = 1'b0;
		mem_wa = r_reg.addr;
		mem_wd = 8'h00;

		// Sequencer: one execute cycle, plus two dummies on a taken skip.
		case (r_reg.fsm)
			XMD_IDLE: begin
				r_next.dcnt = 2'd0;
			end
			XMD_EXEC: begin
				case (r_reg.op)
					XMD_COPY_ACC_TO_MEM: begin
						res = a;
						mem_dst = 1'b1;
					end
					XMD_OR_INTO_ACC, XMD_OR_INTO_MEM: begin
						res = a | m;
						r_next.flags.zero = (res == 8'h00);
						acc_dst = (r_reg.op == XMD_OR_INTO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_ROTATE_LEFT_MEM, XMD_ROTATE_LEFT_TO_ACC: begin
						res = {m[6:0], m[7]};
						acc_dst = (r_reg.op == XMD_ROTATE_LEFT_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_ROTATE_LEFT_CARRY_MEM,
					XMD_ROTATE_LEFT_CARRY_TO_ACC: begin
						res = {m[6:0], c};
						r_next.flags.carry = m[7];
						acc_dst = (r_reg.op == XMD_ROTATE_LEFT_CARRY_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_ROTATE_RIGHT_MEM, XMD_ROTATE_RIGHT_TO_ACC: begin
						res = {m[0], m[7:1]};
						acc_dst = (r_reg.op == XMD_ROTATE_RIGHT_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_ROTATE_RIGHT_CARRY_MEM,
					XMD_ROTATE_RIGHT_CARRY_TO_ACC: begin
						res = {c, m[7:1]};
						r_next.flags.carry = m[0];
						acc_dst = (r_reg.op == XMD_ROTATE_RIGHT_CARRY_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_SUB_BORROW_TO_ACC, XMD_SUB_BORROW_TO_MEM: begin
						s = sub_calc(a, m, ~c,
							r_reg.flags.chained_zero_flag, 1'b1);
						res = s.res;
						r_next.flags = s.flags;
						acc_dst = (r_reg.op == XMD_SUB_BORROW_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_MINUS_TO_ACC, XMD_MINUS_TO_MEM: begin
						s = sub_calc(a, m, 1'b0,
							r_reg.flags.chained_zero_flag, 1'b0);
						res = s.res;
						r_next.flags = s.flags;
						acc_dst = (r_reg.op == XMD_MINUS_TO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_DEC_SKIP_ZERO_MEM, XMD_DEC_SKIP_ZERO_ACC: begin
						res = m - 8'h01;
						skip = (res == 8'h00);
						acc_dst = (r_reg.op == XMD_DEC_SKIP_ZERO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_INC_SKIP_ZERO_MEM, XMD_INC_SKIP_ZERO_ACC: begin
						res = m + 8'h01;
						skip = (res == 8'h00);
						acc_dst = (r_reg.op == XMD_INC_SKIP_ZERO_ACC);
						mem_dst = ~acc_dst;
					end
					XMD_FORCE_ONES: begin
						res = 8'hFF;
						mem_dst = 1'b1;
					end
					XMD_FORCE_BIT: begin
						res = m | bit_mask(r_reg.bsel);
						mem_dst = 1'b1;
					end
					XMD_SKIP_IF_NONZERO: begin
						skip = (m != 8'h00);
					end
					XMD_SKIP_IF_BIT_SET: begin
						skip = ((m & bit_mask(r_reg.bsel)) != 8'h00);
					end
					XMD_NIBBLE_EXCHANGE_MEM: begin
						res = {m[3:0], m[7:4]};
						mem_dst = 1'b1;
					end
					XMD_NIBBLE_EXCHANGE_ACC: begin
						res = {m[3:0], m[7:4]};
						acc_dst = 1'b1;
					end
					default: begin
						res = 8'h00;
					end
				endcase
				// The result lands in this same cycle for every form.
				if (acc_dst) begin
					r_next.acc = res;
				end
				mem_we = mem_dst;
				mem_wd = res;
				// A taken skip holds the core in dummy cycles so the
				// instruction fetched behind it is discarded.
				if (skip) begin
					r_next.fsm = XMD_DUMMY;
					r_next.dcnt = `XMD_SKIP_CYCLES - 2'd1;
					r_next.last_cyc = `XMD_SKIP_CYCLES;
					r_next.skip_cnt = r_reg.skip_cnt + 8'h01;
					r_next.skip_taken = 1'b1;
				end else begin
					r_next.fsm = XMD_IDLE;
					r_next.last_cyc = `XMD_PLAIN_CYCLES;
				end
			end
			XMD_DUMMY: begin
				// Count out the inserted cycles, then release the bus.
				r_next.dcnt = r_reg.dcnt - 2'd1;
				if (r_reg.dcnt == 2'd1) begin
					r_next.fsm = XMD_IDLE;
				end
			end
			default: begin
				r_next.fsm = XMD_IDLE;
			end
		endcase

		// Register writes take effect only at the completing edge; the
		// bus stalls while busy, so they never race the datapath.
		if (access && pwrite && !r_reg.pslverr) begin
			case (paddr)
				`XMD_OFF_CMD: begin
					r_next.op = xmd_op_t'(pwdata[`XMD_CMD_OP_LSB +: 5]);
					r_next.bsel = pwdata[`XMD_CMD_BIT_LSB +: 3];
					r_next.addr = pwdata[`XMD_CMD_ADDR_LSB +: 10];
					r_next.fsm = XMD_EXEC;
				end
				`XMD_OFF_ACC: begin
					r_next.acc = pwdata[7:0];
				end
				`XMD_OFF_FLAGS: begin
					r_next.flags = xmd_flags_t'(pwdata[5:0]);
				end
				`XMD_OFF_MADDR: begin
					r_next.maddr = pwdata[9:0];
				end
				`XMD_OFF_MDATA: begin
					mem_we = 1'b1;
					mem_wa = r_reg.maddr;
					mem_wd = pwdata[7:0];
				end
				default: begin
					// Read-only and unmapped offsets take no write.
				end
			endcase
		end

		r_next.busy = (r_next.fsm != XMD_IDLE);

		// Answer one cycle after setup, held off while an instruction runs.
		r_next.pready = psel & ~r_reg.pready & (r_next.fsm == XMD_IDLE);
		if (r_next.pready) begin
			case (paddr)
				`XMD_OFF_CMD: begin
					hit = 1'b1;
					r_next.prdata = {6'h00, r_reg.addr, 5'h00,
						r_reg.bsel, 3'h0, r_reg.op};
				end
				`XMD_OFF_ACC: begin
					hit = 1'b1;
					r_next.prdata = {24'h000000, r_reg.acc};
				end
				`XMD_OFF_FLAGS: begin
					hit = 1'b1;
					r_next.prdata = {23'h000000, r_reg.busy, 2'b00,
						r_reg.flags};
				end
				`XMD_OFF_MADDR: begin
					hit = 1'b1;
					r_next.prdata = {22'h000000, r_reg.maddr};
				end
				`XMD_OFF_MDATA: begin
					hit = 1'b1;
					r_next.prdata = {24'h000000, mem_view};
				end
				`XMD_OFF_INFO: begin
					hit = 1'b1;
					r_next.prdata = {16'h0000, r_reg.skip_cnt, 6'h00,
						r_reg.last_cyc};
				end
				default: begin
					hit = 1'b0;
					r_next.prdata = 32'h00000000;
				end
			endcase
			// A command with an unknown code is refused like a bad address.
			if (pwrite && paddr == `XMD_OFF_CMD &&
				!op_legal(pwdata[`XMD_CMD_OP_LSB +: 5])) begin
				hit = 1'b0;
			end
			if (pwrite) begin
				r_next.prdata = 32'h00000000;
			end
			r_next.pslverr = ~hit;
		end else begin
			r_next.pslverr = 1'b0;
			r_next.prdata = 32'h00000000;
		end
	end

	// ****************************************
	// Registers
	// ****************************************

	// All control state resets to idle with cleared flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.fsm <= XMD_IDLE;
			r_reg.acc <= `XMD_ACC_RST;
			r_reg.flags <= `XMD_FLAGS_RST;
			r_reg.op <= XMD_COPY_ACC_TO_MEM;
		end else begin
			r_reg <= r_next;
		end
	end

	// Memory has no reset; software initialises it through the data window.
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

endmodule // xmd_core

// *** xmd_core_checker.sv ***
// Concurrent checks on the ports of the extended memory operation datapath.
`timescale 1ns/10ps

module xmd_core_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy,
	input wire logic skip_taken
);
	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// Bus answer properties
	// ****************************************
	// A second high cycle of pready would commit a write twice.
	ready_one_a: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	stall_busy_a: assert property (busy |-> !pready)
		else $error("transfer answered while busy");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	bad_addr_a: assert property (pready && (paddr > 8'h14 ||
		paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped address not refused");
	read_data_a: assert property (!(pready && !pwrite) |->
		prdata == 32'h0)
		else $error("read data outside a read");

	// ****************************************
	// Instruction sequencing properties
	// ****************************************
	cmd_start_a: assert property (pready && pwrite && !pslverr &&
		paddr == 8'h00 |=> busy)
		else $error("command did not start");
	plain_len_a: assert property ($rose(busy) |=> busy == skip_taken)
		else $error("instruction length wrong");
	skip_len_a: assert property (skip_taken |-> busy ##1 busy ##1 !busy)
		else $error("skip did not last three cycles");
	skip_pulse_a: assert property (skip_taken |=> !skip_taken)
		else $error("skip pulse too long");

	// Main scenarios reached.
	skip_c: cover property (skip_taken);
	err_c: cover property (pready && pslverr);
	plain_c: cover property ($rose(busy) ##1 !busy);
endmodule // xmd_core_checker

bind xmd_core xmd_core_checker i_xmd_core_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy(busy), .skip_taken(skip_taken));

// *** xmd_apb_model.sv ***
// Sequencer-side model that issues instructions and register moves over APB.
`timescale 1ns/10ps

module xmd_apb_model (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// Bus idle from time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; the request holds until pready is seen high at an edge.
	// Pready is read just after the rising edge, before the slave's flops
	// move, so the value seen is the one sampled at that edge.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		// Release only at the edge that completed the transfer.
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule // xmd_apb_model

// *** tb_extended_mem_op_datapath.sv ***
// Self-checking bench for the extended memory operation datapath.
`timescale 1ns/10ps
`include "xmd_defines.svh"

module tb_extended_mem_op_datapath import xmd_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic busy, skip_taken, e, sk;
	logic [7:0] paddr, a, m, nsk;
	logic [31:0] pwdata, prdata, q;
	logic [4:0] op;
	logic [2:0] b;
	logic [9:0] ad;
	xmd_flags_t f;
	logic [7:0] cm [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
	int n_errors, n_checks, cyc, n_skip;

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	xmd_core i_xmd_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.skip_taken(skip_taken));
	xmd_apb_model i_xmd_apb_model (.pclk(pclk), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task final_report;
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic io(input logic w, input logic [7:0] ra, input logic [31:0] d);
		i_xmd_apb_model.xfer(w, ra, d, q, e);
	endtask

	// Expected effect of one instruction on accumulator, byte and flags.
	function automatic void ref_op(input logic [4:0] o, input logic [2:0] bi,
		inout logic [7:0] ac, inout logic [7:0] mb, inout xmd_flags_t fl,
		output logic s);
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] r;
		logic bw, ov, z;
		s = 1'b0;
		bw = (o == 5'h0B || o == 5'h0C) ? !fl.carry : 1'b0;
		d = {1'b0, ac} - {1'b0, mb} - {8'h00, bw};
		h = {1'b0, ac[3:0]} - {1'b0, mb[3:0]} - {4'h0, bw};
		ov = (ac[7] ^ mb[7]) & (d[7] ^ ac[7]);
		z = (d[7:0] == 8'h00);
		case (o)
			5'h00: mb = ac;
			5'h01: begin ac = ac | mb; fl.zero = (ac == 8'h00); end
			5'h02: begin mb = ac | mb; fl.zero = (mb == 8'h00); end
			5'h03: mb = {mb[6:0], mb[7]};
			5'h04: ac = {mb[6:0], mb[7]};
			5'h05, 5'h06: begin
				r = {mb[6:0], fl.carry};
				fl.carry = mb[7];
				if (o == 5'h05) mb = r; else ac = r;
			end
			5'h07: mb = {mb[0], mb[7:1]};
			5'h08: ac = {mb[0], mb[7:1]};
			5'h09, 5'h0A: begin
				r = {fl.carry, mb[7:1]};
				fl.carry = mb[0];
				if (o == 5'h09) mb = r; else ac = r;
			end
			5'h0B, 5'h0C, 5'h0D, 5'h0E: begin
				fl.chained_zero_flag = (o < 5'h0D) ? z & fl.chained_zero_flag : z;
				fl = '{fl.chained_zero_flag, d[7] ^ ov, ov, z, !h[4], !d[8]};
				if (o == 5'h0B || o == 5'h0D) ac = d[7:0]; else mb = d[7:0];
			end
			5'h0F: begin mb = mb - 8'h01; s = (mb == 8'h00); end
			5'h10: begin ac = mb - 8'h01; s = (ac == 8'h00); end
			5'h11: begin mb = mb + 8'h01; s = (mb == 8'h00); end
			5'h12: begin ac = mb + 8'h01; s = (ac == 8'h00); end
			5'h13: mb = 8'hFF;
			5'h14: mb[bi] = 1'b1;
			5'h15: s = (mb != 8'h00);
			5'h16: s = mb[bi];
			5'h17: mb = {mb[3:0], mb[7:4]};
			default: ac = {mb[3:0], mb[7:4]};
		endcase
	endfunction

	// Hang guard; a full run needs well under a third of this.
	// The skip pulse is also counted here, so the pin is checked directly.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (skip_taken === 1'b1) n_skip <= n_skip + 1;
		if (cyc == 30000) begin
			n_errors++;
			final_report;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		nsk = 8'h00;
		cyc = 0;
		n_skip = 0;
		n_errors = 0;
		n_checks = 0;
		void'($urandom(89722));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		io(1'b0, `XMD_OFF_ACC, 32'h0);
		check(q, 32'h0);
		io(1'b0, `XMD_OFF_FLAGS, 32'h0);
		check(q, 32'h0);
		io(1'b0, 8'h18, 32'h0);
		check({31'h0, e}, 32'h1);
		io(1'b0, 8'h02, 32'h0);
		check({31'h0, e}, 32'h1);
		io(1'b1, `XMD_OFF_ACC, 32'h5A);
		io(1'b1, `XMD_OFF_CMD, 32'h19);
		check({31'h0, e}, 32'h1);
		io(1'b0, `XMD_OFF_ACC, 32'h0);
		check(q, 32'h5A);
		// Every opcode many times; corner bytes first, random bytes later.
		for (int i = 0; i < 250; i++) begin
			op = 5'(i % 25);
			b = 3'($urandom);
			ad = i[0] ? 10'($urandom) : (i[1] ? 10'h3FF : 10'h000);
			m = (i < 100) ? cm[i % 4] : 8'($urandom);
			a = 8'($urandom);
			f = 6'($urandom);
			io(1'b1, `XMD_OFF_MADDR, {22'h0, ad});
			io(1'b1, `XMD_OFF_MDATA, {24'h0, m});
			io(1'b1, `XMD_OFF_ACC, {24'h0, a});
			io(1'b1, `XMD_OFF_FLAGS, {26'h0, f});
			io(1'b1, `XMD_OFF_CMD, {6'h00, ad, 5'h00, b, 3'h0, op});
			ref_op(op, b, a, m, f, sk);
			if (sk) nsk++;
			io(1'b0, `XMD_OFF_ACC, 32'h0);
			check(q, {24'h0, a});
			io(1'b0, `XMD_OFF_MDATA, 32'h0);
			check(q, {24'h0, m});
			io(1'b0, `XMD_OFF_FLAGS, 32'h0);
			check(q, {26'h0, f});
			io(1'b0, `XMD_OFF_INFO, 32'h0);
			check(q, {16'h0, nsk, 6'h0, sk ? 2'h3 : 2'h1});
		end
		check(32'(n_skip), {24'h0, nsk});
		final_report;
	end
endmodule // tb_extended_mem_op_datapath
